// file: rtl/awu_top.sv
// Halt wake-up timer: mode control, registers over AXI4-Lite, interrupt.
// Assumes CPU strobes and the RC clock sample are synchronous to CLOCK_I.
//
// How it works
// - Halt with wake enable, no RTC: timed halt
// - Halt with RTC interrupt enabled: active halt
// - Timed halt starts RC oscillator and chain
// - RC clock divided by 64 then prescaler
// - Expiry sets wake flag, interrupt ends halt
// - Wake restarts oscillator, waits 256/4096 cycles
// - Reading control/status clears wake flag
// - Measure bit routes RC clock to capture
// - Reset or exit interrupt also ends halt
// - Halt entry forces interrupt mask to 10b
// - Timed halt stops main and peripheral clocks
// - Watchdog option permits halt or resets
// - Wake enable freely writable by software
// - Control/status resets zero, upper bits zero
// - Prescaler resets FFh, factor equals value
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module awu_top
  import awu_pkg::*;
(
  input  wire logic        CLOCK_I,
  input  wire logic        RSTN_I,
  input  wire logic [11:0] S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [11:0] S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        HALT_EXEC_I,
  input  wire logic        RTC_INTERRUPT_ENABLE_I,
  input  wire logic        HALT_EXIT_IRQ_I,
  input  wire logic        WDG_ENABLED_I,
  input  wire logic        WATCHDOG_HALT_OPTION_I,
  input  wire logic        STARTUP_LONG_I,
  input  wire logic        WAKE_RC_CLOCK_I,
  output logic             WAKE_RC_OSC_EN_O,
  output logic             TIMER_CAPTURE_INPUT_ONE_O,
  output logic             MAIN_OSC_EN_O,
  output logic             CPU_CLK_EN_O,
  output logic             PERIPH_CLK_EN_O,
  output logic             TIMED_HALT_MODE_O,
  output logic             ACTIVE_HALT_MODE_O,
  output logic             CC_MASK_FORCE_O,
  output logic [1:0]       CONDITION_CODE_MASK_O,
  output logic             WDG_RESET_O,
  output logic             WAKE_IRQ_O,
  output logic             IRQ_O
);

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [7:0]  idx);
    addr_is = (a == {2'h0, idx, 2'h0});
  endfunction

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = addr_is(a, IDX_CSR) || addr_is(a, IDX_PR) ||
                 addr_is(a, IDX_STAT) || addr_is(a, IDX_MASK);
  endfunction

  typedef struct packed {
    awu_state_t          st;
    logic                wake_en;
    logic                meas_en;
    logic                wake_flag;
    logic [7:0]          prescale;
    logic [STAT_W-1:0]   stat;
    logic [STAT_W-1:0]   mask;
    logic                rc_prev;
    logic                rc_tick;
    logic                chain_restart;
    logic                stab_start;
    logic                aw_got;
    logic [11:0]         awaddr;
    logic                w_got;
    logic [31:0]         wdata;
    logic                wstrb0;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic                rc_osc_en;
    logic                capture;
    logic                main_osc_en;
    logic                cpu_clk_en;
    logic                periph_clk_en;
    logic                timed_mode;
    logic                active_mode;
    logic                cc_force;
    logic [1:0]          cc_mask;
    logic                wdg_reset;
    logic                irq;
  } awu_top_st_t;

  awu_top_st_t r_reg;
  awu_top_st_t r_next;
  logic        stab_done;

  awu_chain_if ch ();

  assign ch.rc_tick  = r_reg.rc_tick;
  assign ch.restart  = r_reg.chain_restart;
  assign ch.run      = (r_reg.st == ST_TIMED);
  assign ch.prescale = r_reg.prescale;

  awu_chain u_chain (
    .clk_i  (CLOCK_I),
    .rstn_i (RSTN_I),
    .ch     (ch.chain)
  );

  awu_stab u_stab (
    .clk_i   (CLOCK_I),
    .rstn_i  (RSTN_I),
    .start_i (r_reg.stab_start),
    .long_i  (STARTUP_LONG_I),
    .done_o  (stab_done)
  );

  always_comb begin
    logic        wr_do;
    logic        rd_do;
    logic        rd_csr;
    logic        rd_stat;
    logic [7:0]  wbyte;
    logic [STAT_W-1:0] ev;
    wr_do   = 1'b0;
    rd_do   = 1'b0;
    rd_csr  = 1'b0;
    rd_stat = 1'b0;
    wbyte   = '0;
    ev      = '0;
    r_next  = r_reg;

    r_next.chain_restart = 1'b0;
    r_next.stab_start    = 1'b0;
    r_next.cc_force      = 1'b0;
    r_next.wdg_reset     = 1'b0;

    // RC clock edge
    r_next.rc_prev = WAKE_RC_CLOCK_I;
    r_next.rc_tick = WAKE_RC_CLOCK_I && !r_reg.rc_prev;

    // Write address and data, either order
    if (S_AXI_AWVALID_I && r_reg.awready) begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && r_reg.wready) begin
      r_next.w_got  = 1'b1;
      r_next.wdata  = S_AXI_WDATA_I;
      r_next.wstrb0 = S_AXI_WSTRB_I[0];
    end
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
      wr_do         = 1'b1;
      r_next.aw_got = 1'b0;
      r_next.w_got  = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp  = addr_known(r_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (r_reg.bvalid && S_AXI_BREADY_I) begin
      r_next.bvalid = 1'b0;
    end

    if (wr_do && r_reg.wstrb0) begin
      wbyte = r_reg.wdata[7:0];
      if (addr_is(r_reg.awaddr, IDX_CSR)) begin
        r_next.wake_en = wbyte[CSR_EN_BIT];
        r_next.meas_en = wbyte[CSR_MEAS_BIT];
      end
      if (addr_is(r_reg.awaddr, IDX_PR) && wbyte != PR_FORBIDDEN) begin
        r_next.prescale = wbyte;
      end
      if (addr_is(r_reg.awaddr, IDX_MASK)) begin
        r_next.mask = wbyte[STAT_W-1:0];
      end
    end

    // Read channel
    if (S_AXI_ARVALID_I && r_reg.arready) begin
      rd_do         = 1'b1;
      rd_csr        = addr_is(S_AXI_ARADDR_I, IDX_CSR);
      rd_stat       = addr_is(S_AXI_ARADDR_I, IDX_STAT);
      r_next.rvalid = 1'b1;
      r_next.rdata  = '0;
      r_next.rresp  = addr_known(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
      if (rd_csr) begin
        r_next.rdata[CSR_FLAG_BIT] = r_reg.wake_flag;
        r_next.rdata[CSR_MEAS_BIT] = r_reg.meas_en;
        r_next.rdata[CSR_EN_BIT]   = r_reg.wake_en;
      end
      if (addr_is(S_AXI_ARADDR_I, IDX_PR)) begin
        r_next.rdata[7:0] = r_reg.prescale;
      end
      if (rd_stat) begin
        r_next.rdata[STAT_W-1:0] = r_reg.stat;
      end
      if (addr_is(S_AXI_ARADDR_I, IDX_MASK)) begin
        r_next.rdata[STAT_W-1:0] = r_reg.mask;
      end
    end else if (r_reg.rvalid && S_AXI_RREADY_I) begin
      r_next.rvalid = 1'b0;
    end

    // Power mode sequencing
    case (r_reg.st)
      ST_RUN: begin
        if (HALT_EXEC_I) begin
          if (WDG_ENABLED_I && !WATCHDOG_HALT_OPTION_I &&
              !RTC_INTERRUPT_ENABLE_I) begin
            r_next.wdg_reset = 1'b1;
            ev[ST_WDG]       = 1'b1;
          end else begin
            r_next.cc_force = 1'b1;
            if (RTC_INTERRUPT_ENABLE_I) begin
              r_next.st = ST_ACTIVE;
            end else if (r_reg.wake_en) begin
              r_next.st            = ST_TIMED;
              r_next.chain_restart = 1'b1;
            end else begin
              r_next.st = ST_HALT;
            end
          end
        end
      end
      ST_HALT, ST_ACTIVE: begin
        if (HALT_EXIT_IRQ_I) begin
          r_next.st         = ST_STARTUP;
          r_next.stab_start = 1'b1;
          ev[ST_EXIT]       = 1'b1;
        end
      end
      ST_TIMED: begin
        if (ch.expire) begin
          r_next.st         = ST_STARTUP;
          r_next.stab_start = 1'b1;
          ev[ST_WAKE]       = 1'b1;
        end else if (HALT_EXIT_IRQ_I) begin
          r_next.st         = ST_STARTUP;
          r_next.stab_start = 1'b1;
          ev[ST_EXIT]       = 1'b1;
        end
      end
      ST_STARTUP: begin
        if (stab_done) begin
          r_next.st = ST_RUN;
        end
      end
      default: begin
        r_next.st = ST_RUN;
      end
    endcase

    // Sticky flags: setting wins over read clear
    r_next.wake_flag = (r_reg.wake_flag && !rd_csr) || ev[ST_WAKE];
    r_next.stat      = (rd_stat ? STAT_RESET : r_reg.stat) | ev;

    // Registered outputs follow the next state; capture follows the current one
    r_next.awready = !r_next.aw_got;
    r_next.wready  = !r_next.w_got;
    r_next.arready = !r_next.rvalid;
    r_next.timed_mode  = (r_next.st == ST_TIMED);
    r_next.active_mode = (r_next.st == ST_ACTIVE);
    r_next.main_osc_en = (r_next.st == ST_RUN) || (r_next.st == ST_ACTIVE) ||
                         (r_next.st == ST_STARTUP);
    r_next.cpu_clk_en    = (r_next.st == ST_RUN);
    r_next.periph_clk_en = (r_next.st == ST_RUN);
    r_next.rc_osc_en = r_next.timed_mode ||
                       (r_next.meas_en && r_next.st == ST_RUN);
    r_next.capture = r_reg.meas_en && (r_reg.st == ST_RUN) &&
                     r_reg.rc_prev;
    if (r_next.cc_force) begin
      r_next.cc_mask = CC_HALT_MASK;
    end
    r_next.irq = |(r_next.stat & r_next.mask);
    if (rd_do || wr_do) begin
      r_next.irq = r_next.irq;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      r_reg               <= '0;
      r_reg.st            <= ST_RUN;
      r_reg.wake_en       <= CSR_RESET[CSR_EN_BIT];
      r_reg.meas_en       <= CSR_RESET[CSR_MEAS_BIT];
      r_reg.wake_flag     <= CSR_RESET[CSR_FLAG_BIT];
      r_reg.prescale      <= PR_RESET;
      r_reg.stat          <= STAT_RESET;
      r_reg.mask          <= STAT_RESET;
      r_reg.awready       <= 1'b1;
      r_reg.wready        <= 1'b1;
      r_reg.arready       <= 1'b1;
      r_reg.main_osc_en   <= 1'b1;
      r_reg.cpu_clk_en    <= 1'b1;
      r_reg.periph_clk_en <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign S_AXI_AWREADY_O           = r_reg.awready;
  assign S_AXI_WREADY_O            = r_reg.wready;
  assign S_AXI_BRESP_O             = r_reg.bresp;
  assign S_AXI_BVALID_O            = r_reg.bvalid;
  assign S_AXI_ARREADY_O           = r_reg.arready;
  assign S_AXI_RDATA_O             = r_reg.rdata;
  assign S_AXI_RRESP_O             = r_reg.rresp;
  assign S_AXI_RVALID_O            = r_reg.rvalid;
  assign WAKE_RC_OSC_EN_O          = r_reg.rc_osc_en;
  assign TIMER_CAPTURE_INPUT_ONE_O = r_reg.capture;
  assign MAIN_OSC_EN_O             = r_reg.main_osc_en;
  assign CPU_CLK_EN_O              = r_reg.cpu_clk_en;
  assign PERIPH_CLK_EN_O           = r_reg.periph_clk_en;
  assign TIMED_HALT_MODE_O         = r_reg.timed_mode;
  assign ACTIVE_HALT_MODE_O        = r_reg.active_mode;
  assign CC_MASK_FORCE_O           = r_reg.cc_force;
  assign CONDITION_CODE_MASK_O     = r_reg.cc_mask;
  assign WDG_RESET_O               = r_reg.wdg_reset;
  assign WAKE_IRQ_O                = r_reg.wake_flag;
  assign IRQ_O                     = r_reg.irq;

endmodule // awu_top

// file: rtl/awu_pkg.sv
// Constants, field layouts and state codes of the halt wake-up timer.
// Assumes a single 40 MHz system clock and an AXI4-Lite register port.
package awu_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CSR      = 8'h2b;
  localparam logic [7:0]  IDX_PR       = 8'h2c;
  localparam logic [7:0]  IDX_STAT     = 8'h2d;
  localparam logic [7:0]  IDX_MASK     = 8'h2e;
  localparam int          ADDR_W       = 12;

  // Control/status fields
  localparam int          CSR_EN_BIT   = 0;
  localparam int          CSR_MEAS_BIT = 1;
  localparam int          CSR_FLAG_BIT = 2;
  localparam logic [7:0]  CSR_RESET    = 8'h00;
  localparam logic [7:0]  PR_RESET     = 8'hff;
  localparam logic [7:0]  PR_FORBIDDEN = 8'h00;

  // Event status and mask layout
  localparam int          STAT_W       = 3;
  localparam int          ST_WAKE      = 0;
  localparam int          ST_EXIT      = 1;
  localparam int          ST_WDG       = 2;
  localparam logic [2:0]  STAT_RESET   = 3'h0;

  // Interrupt mask level forced at halt entry
  localparam logic [1:0]  CC_HALT_MASK = 2'h2;

  // Counting chain
  localparam logic [5:0]  DIV_LAST     = 6'h3f;
  localparam logic [7:0]  CNT_ONE      = 8'h01;

  // Main oscillator stabilisation, in CPU cycles
  localparam int          STAB_SHORT   = 256;
  localparam int          STAB_LONG    = 4096;
  localparam logic [12:0] STAB_SHORT_LD = 13'(STAB_SHORT - 1);
  localparam logic [12:0] STAB_LONG_LD  = 13'(STAB_LONG - 1);

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [4:0] {
    ST_RUN     = 5'h01,
    ST_HALT    = 5'h02,
    ST_ACTIVE  = 5'h04,
    ST_TIMED   = 5'h08,
    ST_STARTUP = 5'h10
  } awu_state_t;

endpackage

// file: rtl/awu_chain_if.sv
// Signals between the mode controller and the wake-up counting chain.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface awu_chain_if;
  logic       rc_tick;
  logic       restart;
  logic       run;
  logic [7:0] prescale;
  logic       expire;
  modport ctrl  (output rc_tick, restart, run, prescale, input expire);
  modport chain (input rc_tick, restart, run, prescale, output expire);
endinterface

// file: rtl/awu_chain.sv
// Fixed divide-by-64 followed by the programmable prescaler count.
// Assumes rc_tick is a one-cycle pulse per RC oscillator period.
`timescale 1ns/1ps
module awu_chain
  import awu_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  awu_chain_if.chain  ch
);

  typedef struct packed {
    logic [5:0] div;
    logic [7:0] cnt;
    logic       expire;
  } awu_chain_st_t;

  awu_chain_st_t r_reg;
  awu_chain_st_t r_next;

  always_comb begin
    r_next        = r_reg;
    r_next.expire = 1'b0;
    if (ch.restart) begin
      r_next.div = '0;
      r_next.cnt = ch.prescale;
    end else if (ch.run && ch.rc_tick) begin
      r_next.div = 6'(r_reg.div + 6'h01);
      if (r_reg.div == DIV_LAST) begin
        if (r_reg.cnt <= CNT_ONE) begin
          r_next.expire = 1'b1;
        end else begin
          r_next.cnt = 8'(r_reg.cnt - CNT_ONE);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r_reg <= '{div: '0, cnt: PR_RESET, expire: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign ch.expire = r_reg.expire;

endmodule // awu_chain

// file: rtl/awu_stab.sv
// Main oscillator stabilisation delay of 256 or 4096 cycles.
// Assumes start is a one-cycle pulse; done pulses once at the end.
`timescale 1ns/1ps
module awu_stab
  import awu_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic start_i,
  input  wire logic long_i,
  output logic      done_o
);

  typedef struct packed {
    logic        busy;
    logic [12:0] cnt;
    logic        done;
  } awu_stab_st_t;

  awu_stab_st_t r_reg;
  awu_stab_st_t r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (start_i) begin
      r_next.busy = 1'b1;
      r_next.cnt  = long_i ? STAB_LONG_LD : STAB_SHORT_LD;
    end else if (r_reg.busy) begin
      if (r_reg.cnt == '0) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end else begin
        r_next.cnt = 13'(r_reg.cnt - 13'h0001);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done_o = r_reg.done;

endmodule // awu_stab

// file: tb/awu_properties.sv
// Concurrent checks on the halt wake-up timer's top-level ports.
// Assumes a bind to awu_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module awu_properties (
  input wire logic       CLOCK_I,
  input wire logic       RSTN_I,
  input wire logic       HALT_EXEC_I,
  input wire logic       RTC_INTERRUPT_ENABLE_I,
  input wire logic       HALT_EXIT_IRQ_I,
  input wire logic       WDG_ENABLED_I,
  input wire logic       WATCHDOG_HALT_OPTION_I,
  input wire logic       STARTUP_LONG_I,
  input wire logic       WAKE_RC_CLOCK_I,
  input wire logic       WAKE_RC_OSC_EN_O,
  input wire logic       TIMER_CAPTURE_INPUT_ONE_O,
  input wire logic       MAIN_OSC_EN_O,
  input wire logic       CPU_CLK_EN_O,
  input wire logic       PERIPH_CLK_EN_O,
  input wire logic       TIMED_HALT_MODE_O,
  input wire logic       ACTIVE_HALT_MODE_O,
  input wire logic       CC_MASK_FORCE_O,
  input wire logic [1:0] CONDITION_CODE_MASK_O,
  input wire logic       WDG_RESET_O,
  input wire logic       WAKE_IRQ_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);

  timed_entry_a: assert property (
    $rose(TIMED_HALT_MODE_O) |-> $past(HALT_EXEC_I) &&
    !$past(RTC_INTERRUPT_ENABLE_I) && $past(CPU_CLK_EN_O))
    else $error("timed halt without halt request");
  active_entry_a: assert property (
    HALT_EXEC_I && CPU_CLK_EN_O && RTC_INTERRUPT_ENABLE_I
    |=> ACTIVE_HALT_MODE_O && MAIN_OSC_EN_O)
    else $error("active halt not entered");
  halt_clocks_a: assert property (
    TIMED_HALT_MODE_O |-> !MAIN_OSC_EN_O && !CPU_CLK_EN_O &&
    !PERIPH_CLK_EN_O && WAKE_RC_OSC_EN_O)
    else $error("clocks wrong in timed halt");
  mask_force_a: assert property (
    HALT_EXEC_I && CPU_CLK_EN_O && (RTC_INTERRUPT_ENABLE_I ||
    !WDG_ENABLED_I || WATCHDOG_HALT_OPTION_I)
    |=> CC_MASK_FORCE_O && CONDITION_CODE_MASK_O == 2'h2)
    else $error("mask not forced at halt entry");
  wdg_reset_a: assert property (
    HALT_EXEC_I && CPU_CLK_EN_O && WDG_ENABLED_I &&
    !WATCHDOG_HALT_OPTION_I && !RTC_INTERRUPT_ENABLE_I
    |=> WDG_RESET_O && CPU_CLK_EN_O)
    else $error("watchdog reset missing");
  wake_flag_a: assert property (
    $rose(WAKE_IRQ_O) |-> $past(TIMED_HALT_MODE_O) &&
    MAIN_OSC_EN_O && !CPU_CLK_EN_O)
    else $error("wake flag outside expiry");
  stab_delay_a: assert property (
    $rose(MAIN_OSC_EN_O) && !STARTUP_LONG_I
    |-> ##250 !CPU_CLK_EN_O ##[1:12] CPU_CLK_EN_O)
    else $error("short stabilisation wrong");
  capture_route_a: assert property (
    TIMER_CAPTURE_INPUT_ONE_O |-> $past(WAKE_RC_CLOCK_I, 2))
    else $error("capture not from rc clock");
  exit_irq_a: assert property (
    TIMED_HALT_MODE_O && HALT_EXIT_IRQ_I
    |=> !TIMED_HALT_MODE_O && MAIN_OSC_EN_O)
    else $error("exit interrupt ignored");
endmodule // awu_properties

// file: tb/awu_rc_model.sv
// Behavioural wake RC oscillator at the far side of the block.
// Assumes its enable is synchronous to the system clock.
`timescale 1ns/1ps
module awu_rc_model #(
  parameter int HALF    = 2,
  parameter int STARTUP = 6
) (
  input  wire logic clk_i,
  input  wire logic en_i,
  output logic      rc_o = 1'b0
);
  int cnt = 0;

  // Stands at 0 while off, toggles after start-up
  always @(posedge clk_i) begin
    if (!en_i) begin
      cnt  <= 0;
      rc_o <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      if (cnt >= STARTUP && (cnt - STARTUP) % HALF == HALF - 1) begin
        rc_o <= ~rc_o;
      end
    end
  end
endmodule // awu_rc_model

// file: tb/awu_top_bench.sv
// Self-checking bench of the halt wake-up timer.
// Assumes awu_top, awu_rc_model and awu_properties are compiled first.
`timescale 1ns/1ps
module awu_top_bench
  import awu_pkg::*;
;
  localparam int RCS = 6;
  logic        clk, rstn, awv, wv, bry, arv, rry, halt, rtc, xirq;
  logic        wdg, wopt, slong, awrdy, wrdy, bvld, arrdy, rvld, oscen;
  logic        cap, mosc, cpu, per, timed, act, ccf, wrst, wirq, irq, rc;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0]  ws;
  logic [1:0]  br, rr, ccm;
  logic [7:0]  v, p;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          i, n, d, s, e, st;

  awu_top u_awu_top (
    .CLOCK_I(clk), .RSTN_I(rstn), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
    .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bvld), .S_AXI_BREADY_I(bry),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rvld),
    .S_AXI_RREADY_I(rry), .HALT_EXEC_I(halt), .RTC_INTERRUPT_ENABLE_I(rtc),
    .HALT_EXIT_IRQ_I(xirq), .WDG_ENABLED_I(wdg),
    .WATCHDOG_HALT_OPTION_I(wopt), .STARTUP_LONG_I(slong),
    .WAKE_RC_CLOCK_I(rc), .WAKE_RC_OSC_EN_O(oscen),
    .TIMER_CAPTURE_INPUT_ONE_O(cap), .MAIN_OSC_EN_O(mosc),
    .CPU_CLK_EN_O(cpu), .PERIPH_CLK_EN_O(per), .TIMED_HALT_MODE_O(timed),
    .ACTIVE_HALT_MODE_O(act), .CC_MASK_FORCE_O(ccf),
    .CONDITION_CODE_MASK_O(ccm), .WDG_RESET_O(wrst), .WAKE_IRQ_O(wirq),
    .IRQ_O(irq));
  awu_rc_model #(.HALF(2), .STARTUP(RCS)) u_awu_rc_model (
    .clk_i(clk), .en_i(oscen), .rc_o(rc));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write one register; both channels offered together
  task automatic wr(input logic [7:0] x, dt, input logic [1:0] er);
    int k = 0;
    @(posedge clk);
    awa <= {2'h0, x, 2'h0};
    wd  <= {24'h0, dt};
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bvld && k < 100);
    chk("bvalid", bvld, 1'b1);
    bry <= 1'b0;
    chk("bresp", {30'h0, br}, {30'h0, er});
  endtask

  task automatic rchk(input string nm, input logic [7:0] x,
                      input logic [31:0] ex, input logic [1:0] er);
    int k = 0;
    @(posedge clk);
    ara <= {2'h0, x, 2'h0};
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (arv && arrdy) arv <= 1'b0;
    end while (!rvld && k < 100);
    chk("rvalid", rvld, 1'b1);
    rry <= 1'b0;
    chk(nm, rdat, ex);
    chk("rresp", {30'h0, rr}, {30'h0, er});
  endtask

  // Halt strobe with the mode inputs set at the same edge
  // Returns just after the entry edge, while entry pulses stand
  task automatic hlt(input logic r, w, o, x);
    @(posedge clk);
    {rtc, wdg, wopt, xirq, halt} <= {r, w, o, x, 1'b1};
    @(posedge clk);
    halt <= 1'b0;
    #1;
  endtask

  task automatic wcpu(output int c);
    @(posedge clk);
    {rtc, wdg, wopt, xirq} <= 4'h0;
    c = 1;
    while (cpu !== 1'b1 && c < 5000) begin
      @(posedge clk);
      c++;
    end
  endtask

  initial begin
    {awv, wv, bry, arv, rry, halt, rtc, xirq, wdg, wopt, slong} = '0;
    {rstn, awa, ara, wd, ws} = {1'b0, 12'h0, 12'h0, 32'h0, 4'h1};
    void'($urandom(32'h37d4));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk("rst_out", {mosc, cpu, per, timed, ccm, irq}, 7'h70);
    rchk("csr_rst", IDX_CSR, 32'h0, RESP_OKAY);
    rchk("pr_rst", IDX_PR, 32'hff, RESP_OKAY);
    wr(IDX_CSR, 8'hff, RESP_OKAY);
    rchk("csr_bits", IDX_CSR, 32'h3, RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom_range(255, 1));
      wr(IDX_PR, v, RESP_OKAY);
      rchk("pr_rw", IDX_PR, {24'h0, v}, RESP_OKAY);
    end
    wr(IDX_PR, PR_FORBIDDEN, RESP_OKAY);
    rchk("pr_zero", IDX_PR, {24'h0, v}, RESP_OKAY);
    wr(8'h30, 8'h01, RESP_SLVERR);
    rchk("unmapped", 8'h30, 32'h0, RESP_SLVERR);
    wr(IDX_CSR, 8'h02, RESP_OKAY);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n += int'(cap);
    end
    chk("measure", {oscen, 1'(n > 0)}, 2'h3);
    for (i = 0; i < 2; i++) begin
      p = (i == 0) ? 8'h01 : 8'($urandom_range(3, 2));
      slong <= i[0];
      wr(IDX_PR, p, RESP_OKAY);
      wr(IDX_MASK, {7'h0, ~i[0]}, RESP_OKAY);
      wr(IDX_CSR, 8'h01, RESP_OKAY);
      hlt(0, 0, 0, 0);
      chk("timed", {timed, ccm, mosc, cpu, per, oscen}, 7'h61);
      d = 0;
      while (timed === 1'b1 && d < 9000) begin
        @(posedge clk);
        d++;
      end
      e = RCS + 256 * int'(p);
      chk("halt_len", 1'(d >= e - 4 && d <= e + 12), 1'b1);
      #1;
      chk("wake", {wirq, irq, mosc, cpu}, {1'b1, ~i[0], 2'h2});
      wcpu(s);
      st = (i == 0) ? STAB_SHORT : STAB_LONG;
      chk("stab", 1'(s >= st - 3 && s <= st + 6), 1'b1);
      rchk("flag", IDX_CSR, 32'h5, RESP_OKAY);
      chk("flag_clr", wirq, 1'b0);
      rchk("status", IDX_STAT, 32'h1, RESP_OKAY);
      chk("irq_clr", irq, 1'b0);
    end
    hlt(1, 0, 0, 0);
    chk("active", {act, mosc, ccf, timed}, 4'he);
    @(posedge clk);
    xirq <= 1'b1;
    wcpu(s);
    chk("act_exit", {act, cpu}, 2'h1);
    wr(IDX_PR, 8'hff, RESP_OKAY);
    hlt(0, 0, 0, 0);
    repeat (20) @(posedge clk);
    xirq <= 1'b1;
    wcpu(s);
    chk("irq_exit", {timed, cpu}, 2'h1);
    rchk("no_flag", IDX_CSR, 32'h1, RESP_OKAY);
    hlt(0, 0, 0, 0);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk("rst_exit", {timed, cpu, mosc}, 3'h3);
    hlt(0, 1, 0, 0);
    chk("wdg_rst", {wrst, cpu, timed, ccf}, 4'hc);
    hlt(0, 1, 1, 1);
    chk("wdg_halt", {ccf, ccm, cpu, mosc}, 5'h18);
    wcpu(s);
    chk("pend_exit", cpu, 1'b1);
    conclude();
  end
endmodule // awu_top_bench

bind awu_top awu_properties u_awu_properties (.*);
